// *** logic/sps_servo_gen.sv ***
// Operation
// - 16-bit period counter overflows every 20 ms
// - Period overflow raises pulse and starts width counter
// - Width overflow drops pulse, halts width counter
// - Width counter preload set so pulse length is linear in conversion result
// - Zero to full scale gives 0.5 ms to just under 2.5 ms
// - Selector level picks which set-point is converted
`timescale 1ns/1ps
`default_nettype none
module sps_servo_gen #(
    // Long counts, shortened in simulation
    parameter int P_TICK_CYCLES  = sps_pkg::TICK_CYCLES,       // Core cycles per tick
    parameter int P_PERIOD_TICKS = sps_pkg::PERIOD_TICKS,      // Ticks per output period
    parameter int P_MIN_TICKS    = sps_pkg::PULSE_MIN_TICKS,   // Pulse ticks at zero reading
    parameter int P_SPAN_TICKS   = sps_pkg::PULSE_SPAN_TICKS   // Span of extra ticks; full scale gets just under it
) (
    // Clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    // Two-state position selector pin
    input  wire logic                  i_position_select_input,
    // Converter handshake
    output sps_pkg::sps_adc_req_t      o_adc_req,
    input  wire sps_pkg::sps_adc_rsp_t i_adc_rsp,
    // Servo control pulse
    output logic                       o_servo_pulse
);
    // Short names for the counter and converter widths
    localparam int CW = sps_pkg::CNT_W;                        // Counter width
    localparam int AW = sps_pkg::ADC_W;                        // Converter result width

    // Preload that makes a 16-bit up-counter overflow after the given ticks
    // Up-counters with a preload give the overflow timing that both counters need;
    // a count of zero would wrap to a full 65536 ticks, so callers never pass it
    function automatic logic [CW-1:0] preload(input int ticks);
        logic [CW:0] full;
        full = {1'b1, {CW{1'b0}}} - (CW+1)'(ticks);
        return full[CW-1:0];
    endfunction : preload

    // Pulse length in ticks, linear in the reading
    // A zero reading gives exactly the shortest pulse, full scale just under the longest
    function automatic int width_ticks(input logic [AW-1:0] data);
        logic [AW+CW-1:0] prod;
        prod = (AW+CW)'(data) * (AW+CW)'(P_SPAN_TICKS);
        // Dividing by 2^AW keeps the top reading a hair under the span
        return P_MIN_TICKS + int'(prod >> AW);
    endfunction : width_ticks

    // Pulse state machine
    // Two states only: one-hot keeps each decode to a single bit
    typedef enum logic [1:0] {
        SPS_PL_WAIT  = 2'b01,                                  // Output low, counter halted
        SPS_PL_HIGH  = 2'b10                                   // Output high, counter running
    } sps_pulse_st_t;

    // Conversion state machine
    typedef enum logic [1:0] {
        SPS_CV_IDLE  = 2'b01,                                  // No conversion outstanding
        SPS_CV_BUSY  = 2'b10                                   // Waiting for done
    } sps_conv_st_t;

    // Selector, timing chain and counters
    logic                   sel_sync;                          // Synchronised selector level
    logic [15:0]            tick_cnt_q;                        // Tick prescaler
    logic                   tick;                              // One-cycle tick strobe
    logic [CW-1:0]          period_cnt_q;                      // Period counter
    logic                   period_evt;                        // Period overflow strobe
    logic [CW-1:0]          width_cnt_q;                       // Pulse-width counter
    logic                   width_ovf;                         // Width overflow strobe
    // State machines and registered outputs
    sps_pulse_st_t          pulse_st_q;                        // Pulse state
    sps_conv_st_t           conv_st_q;                         // Conversion state
    logic [AW-1:0]          result_q;                          // Latest conversion result
    logic                   start_q;                           // Start strobe register
    logic                   chan_q;                            // Channel register
    logic                   pulse_q;                           // Output pulse register
    logic                   boot_q;                            // First conversion not yet asked

    // Selector comes from a pin: two flops before any use
    // Both stages reset low, so the boot conversion always reads set-point A
    sps_sync u_sel_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_async    (i_position_select_input),
        .o_sync     (sel_sync)
    );

    // Tick prescaler; both counters step on the same tick so timing is exact
    // A 1 us tick trades pulse resolution for 16-bit counters that span 20 ms
    assign tick = (tick_cnt_q == 16'(P_TICK_CYCLES - 1));

    always_ff @(posedge i_core_clk) begin
        if (i_rst || tick) begin
            // Reset and wrap share a branch, so counting restarts in phase
            tick_cnt_q <= 16'h0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
        end
    end

    // Period counter, reloaded on its own overflow
    // The reset preload puts the first event one full period after release
    assign period_evt = tick && (period_cnt_q == sps_pkg::CNT_TOP);

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            period_cnt_q <= preload(P_PERIOD_TICKS);
        end else if (period_evt) begin
            period_cnt_q <= preload(P_PERIOD_TICKS);
        end else if (tick) begin
            period_cnt_q <= period_cnt_q + 16'h0001;
        end
    end

    // Width counter overflow only matters while the pulse is high
    // Qualifying with the state keeps a halted counter at the top from starting conversions
    assign width_ovf = tick && (pulse_st_q == SPS_PL_HIGH) && (width_cnt_q == sps_pkg::CNT_TOP);

    // Width counter: preloaded on the period event, halted when low
    // Only the state term in width_ovf keeps the counter halted at the top from firing a second overflow
    // Limitation: a reading that lands mid-pulse only serves the next period
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            width_cnt_q <= sps_pkg::CNT_TOP;
        end else if (period_evt) begin
            width_cnt_q <= preload(width_ticks(result_q));
        end else if (tick && (pulse_st_q == SPS_PL_HIGH) && !width_ovf) begin
            width_cnt_q <= width_cnt_q + 16'h0001;
        end
    end

    // Pulse state and output
    // The pin comes from its own flop, moved together with the state
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            pulse_st_q <= SPS_PL_WAIT;
            pulse_q    <= 1'b0;
        end else begin
            unique case (pulse_st_q)
                SPS_PL_WAIT: begin
                    // Pin low, counter halted, waiting for the period event
                    if (period_evt) begin
                        pulse_st_q <= SPS_PL_HIGH;
                        pulse_q    <= 1'b1;
                    end
                end
                SPS_PL_HIGH: begin
                    // A period event cannot land here: the longest pulse is far shorter
                    if (width_ovf) begin
                        pulse_st_q <= SPS_PL_WAIT;
                        pulse_q    <= 1'b0;
                    end
                end
                default: begin
                    // Illegal code: fall back to waiting with the pin low
                    pulse_st_q <= SPS_PL_WAIT;
                    pulse_q    <= 1'b0;
                end
            endcase
        end
    end

    // Boot flag: ask for one conversion straight after reset
    // Without it the first period would run on the reset result, not on a reading
    // It drops on the first idle cycle, the same edge at which the start is raised
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            boot_q <= 1'b1;
        end else if (conv_st_q == SPS_CV_IDLE) begin
            boot_q <= 1'b0;
        end
    end

    // Conversion sequencing: start at pulse end so the result is ready well before
    // the next period event; channel follows the selector at the start
    // A pulse end while still busy skips that conversion and the old result stays;
    // a converter slower than one period therefore leaves some periods stale
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            conv_st_q <= SPS_CV_IDLE;
            start_q   <= 1'b0;
            chan_q    <= sps_pkg::CHAN_A;
        end else begin
            // Start is a strobe: low unless raised below for one cycle
            start_q <= 1'b0;
            unique case (conv_st_q)
                SPS_CV_IDLE: begin
                    if (width_ovf || boot_q) begin
                        conv_st_q <= SPS_CV_BUSY;
                        start_q   <= 1'b1;
                        chan_q    <= sel_sync;
                    end
                end
                SPS_CV_BUSY: begin
                    // The answer has no timeout; the converter must always finish
                    if (i_adc_rsp.done) begin
                        conv_st_q <= SPS_CV_IDLE;
                    end
                end
                default: begin
                    // Illegal code: fall back to idle
                    conv_st_q <= SPS_CV_IDLE;
                end
            endcase
        end
    end

    // Result register; a late answer simply serves the following period
    // A done while idle is ignored, so a stray answer cannot alter the width
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            result_q <= sps_pkg::ADC_RST;
        end else if ((conv_st_q == SPS_CV_BUSY) && i_adc_rsp.done) begin
            result_q <= i_adc_rsp.data;
        end
    end

    // Outputs come straight from flops; the request struct is driven as a whole
    assign o_adc_req     = '{start: start_q, chan: chan_q};
    assign o_servo_pulse = pulse_q;
endmodule : sps_servo_gen
`default_nettype wire

// *** common/sps_pkg.sv ***
`default_nettype none
package sps_pkg;
    // Core clock
    localparam int CLK_PERIOD_PS   = 5000;                     // 200 MHz core clock, in ps
    // Timing base: all long times are counted in ticks
    localparam int TICK_NS         = 1000;                     // One tick lasts 1 us
    localparam int TICK_CYCLES     = (TICK_NS * 1000) / CLK_PERIOD_PS;
    // Output period
    localparam int PERIOD_MS       = 20;                       // Pulse repetition period
    localparam int PERIOD_TICKS    = (PERIOD_MS * 1000000) / TICK_NS;
    // Pulse length span over the full converter range
    localparam int PULSE_MIN_US    = 500;                      // Length at a zero reading
    localparam int PULSE_MAX_US    = 2500;                     // Upper length limit; a full-scale reading falls just under it
    localparam int PULSE_MIN_TICKS = (PULSE_MIN_US * 1000) / TICK_NS;
    localparam int PULSE_SPAN_TICKS = ((PULSE_MAX_US - PULSE_MIN_US) * 1000) / TICK_NS;
    // Counter and converter widths
    localparam int CNT_W           = 16;                       // Both counters are 16 bits
    localparam int ADC_W           = 10;                       // Conversion result width
    localparam logic [CNT_W-1:0] CNT_TOP = 16'hffff;           // Value at which a counter overflows
    localparam logic [ADC_W-1:0] ADC_RST = 10'h000;            // Result held until first conversion
    localparam logic             CHAN_A  = 1'b0;               // Selector low picks set-point A

    // Request toward the converter
    typedef struct packed {
        logic start;                                           // One-cycle start strobe
        logic chan;                                            // Input multiplexer channel
    } sps_adc_req_t;

    // Answer from the converter
    typedef struct packed {
        logic             done;                                // One-cycle completion strobe
        logic [ADC_W-1:0] data;                                // Result, valid with done
    } sps_adc_rsp_t;
endpackage : sps_pkg
`default_nettype wire

// *** logic/sps_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for a level from a pin
module sps_sync (
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    // Asynchronous level in, synchronised level out
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_q;   // First stage, read only by the second stage
    logic sync_q;   // Second stage, safe to use

    // Both stages clear on reset so the selector reads low at start-up
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule : sps_sync
`default_nettype wire

// *** test/sps_servo_gen_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// Watches pulse timing and the converter handshake at the top ports
module sps_chk #(
    parameter int P_TICK_CYCLES  = 4,
    parameter int P_PERIOD_TICKS = 100,
    parameter int P_MIN_TICKS    = 5,
    parameter int P_SPAN_TICKS   = 20
) (
    // Clock and reset
    input wire logic                  i_core_clk,
    input wire logic                  i_rst,
    // Selector, converter link, pulse
    input wire logic                  i_position_select_input,
    input wire sps_pkg::sps_adc_req_t o_adc_req,
    input wire sps_pkg::sps_adc_rsp_t i_adc_rsp,
    input wire logic                  o_servo_pulse
);
    localparam int WMIN = P_MIN_TICKS * P_TICK_CYCLES;                  // Shortest pulse
    localparam int WMAX = (P_MIN_TICKS + P_SPAN_TICKS) * P_TICK_CYCLES; // Just above the longest pulse
    localparam int PER  = P_PERIOD_TICKS * P_TICK_CYCLES;               // Rise to rise
    int   hi_q;   // Cycles the pulse has stood high
    int   per_q;  // Cycles since the last rise
    logic seen_q; // A rise was seen, so the period count is meaningful
    logic prev_q; // Pulse one cycle back
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // Counters kept here because repetitions cannot span whole periods
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            hi_q   <= 0;
            per_q  <= 0;
            seen_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            hi_q   <= o_servo_pulse ? hi_q + 1 : 0;
            per_q  <= (o_servo_pulse && !prev_q) ? 1 : per_q + 1;
            seen_q <= seen_q | (o_servo_pulse & !prev_q);
            prev_q <= o_servo_pulse;
        end
    end
    // Pulse end step of the cycle
    sequence s_end;
        $fell(o_servo_pulse);
    endsequence
    pulse_max_a: assert property (o_servo_pulse |-> hi_q < WMAX)
        else $error("pulse longer than the longest allowed");
    pulse_min_a: assert property (s_end |-> hi_q >= WMIN)
        else $error("pulse shorter than the shortest allowed");
    tick_whole_a: assert property (s_end |-> hi_q % P_TICK_CYCLES == 0)
        else $error("pulse not a whole number of ticks");
    period_len_a: assert property ($rose(o_servo_pulse) && seen_q |-> per_q == PER)
        else $error("rising edges not one period apart");
    pulse_hold_a: assert property ($rose(o_servo_pulse) |-> o_servo_pulse [*8])
        else $error("pulse dropped right after rising");
    end_start_a: assert property (s_end |-> o_adc_req.start)
        else $error("no conversion started at pulse end");
    start_one_a: assert property (o_adc_req.start |=> !o_adc_req.start)
        else $error("start strobe longer than one cycle");
    chan_hold_a: assert property ($changed(o_adc_req.chan) |-> o_adc_req.start)
        else $error("channel moved outside a start");
    // Channel at a start is the pin as sampled three edges before, through the synchroniser
    sequence s_chan_ok;
        o_adc_req.chan == $past(i_position_select_input, 3);
    endsequence
    chan_follow_a: assert property (o_adc_req.start && seen_q |-> s_chan_ok)
        else $error("channel not taken from the selector");
endmodule : sps_chk
bind sps_servo_gen sps_chk #(.P_TICK_CYCLES(P_TICK_CYCLES), .P_PERIOD_TICKS(P_PERIOD_TICKS),
    .P_MIN_TICKS(P_MIN_TICKS), .P_SPAN_TICKS(P_SPAN_TICKS)) u_chk (.i_core_clk(i_core_clk),
    .i_rst(i_rst), .i_position_select_input(i_position_select_input), .o_adc_req(o_adc_req),
    .i_adc_rsp(i_adc_rsp), .o_servo_pulse(o_servo_pulse));
`default_nettype wire

// *** test/sps_conv_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Converter with two set-point inputs and a programmable conversion time
module sps_conv_model (
    // Clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    // Handshake with the generator
    input  wire sps_pkg::sps_adc_req_t i_req,
    output sps_pkg::sps_adc_rsp_t      o_rsp,
    // Set-point levels and conversion time in cycles
    input  wire logic [9:0]            i_level_a,
    input  wire logic [9:0]            i_level_b,
    input  wire logic [7:0]            i_delay
);
    logic       busy_q; // Conversion running
    logic       chan_q; // Channel taken at start
    logic [7:0] cnt_q;  // Cycles left
    // Data lines toggle outside done so a stale sample cannot pass
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            busy_q <= 1'b0;
            cnt_q  <= 8'h00;
            chan_q <= 1'b0;
            o_rsp  <= '0;
        end else begin
            o_rsp.done <= 1'b0;
            o_rsp.data <= ~o_rsp.data;
            if (i_req.start) begin
                busy_q <= 1'b1;
                cnt_q  <= i_delay;
                chan_q <= i_req.chan;
            end else if (busy_q && cnt_q == 8'h00) begin
                busy_q     <= 1'b0;
                o_rsp.done <= 1'b1;
                o_rsp.data <= (chan_q == sps_pkg::CHAN_A) ? i_level_a : i_level_b;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule : sps_conv_model
`default_nettype wire

// *** test/two_position_servo_pulse_gen_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module two_position_servo_pulse_gen_tb_top;
    logic                  clk = 1'b0;     // Core clock
    logic                  rst = 1'b1;     // Held for five cycles
    logic                  sel = 1'b0;     // Selector pin
    logic [9:0]            lva = 10'h000;  // Set-point A level
    logic [9:0]            lvb = 10'h3ff;  // Set-point B level
    logic [7:0]            dly = 8'h03;    // Prompt converter first
    sps_pkg::sps_adc_req_t req;
    sps_pkg::sps_adc_rsp_t rsp;
    logic                  pulse;
    int errors = 0, checks = 0, cyc = 0, last_rise = 0, w, p;
    // Short counts keep the run brief; expectations reuse the same figures
    localparam int TCK  = 4;    // Core cycles per tick
    localparam int PERT = 100;  // Ticks per period
    localparam int MINT = 5;    // Pulse ticks at a zero reading
    localparam int SPNT = 20;   // Extra-tick span; a full-scale reading gets just under it
    always #2.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    sps_servo_gen #(.P_TICK_CYCLES(TCK), .P_PERIOD_TICKS(PERT), .P_MIN_TICKS(MINT),
                    .P_SPAN_TICKS(SPNT))
        u_dut (.i_core_clk(clk), .i_rst(rst), .i_position_select_input(sel),
               .o_adc_req(req), .i_adc_rsp(rsp), .o_servo_pulse(pulse));
    sps_conv_model u_model (.i_core_clk(clk), .i_rst(rst), .i_req(req), .o_rsp(rsp),
                            .i_level_a(lva), .i_level_b(lvb), .i_delay(dly));
    // Expected width in cycles for a reading
    function automatic int exp_w(input logic [9:0] d);
        return (MINT + (int'(d) * SPNT) / (1 << sps_pkg::ADC_W)) * TCK;
    endfunction : exp_w
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %0d seen %0d", name, exp, seen);
        end
    endtask : check
    // Next pulse: width in cycles and distance from the previous rise
    task automatic measure(output int wd, output int pd);
        int n;
        n = 0;
        while (pulse !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        check("pulse arrival", int'(n < 1000), 1);
        pd = cyc - last_rise;
        last_rise = cyc;
        wd = 0;
        while (pulse === 1'b1 && wd < 1000) begin
            @(negedge clk);
            wd++;
        end
    endtask : measure
    task automatic t_boot();
        measure(w, p);
        check("boot width", w, exp_w(10'h000));
        measure(w, p);
        check("period", p, TCK * PERT);
    endtask : t_boot
    // Selector flips after a conversion began: effect lands one period later
    task automatic t_select();
        @(posedge clk) sel <= 1'b1;
        measure(w, p);
        check("held width", w, exp_w(10'h000));
        measure(w, p);
        check("selected width", w, exp_w(10'h3ff));
        check("period", p, TCK * PERT);
    endtask : t_select
    // Slow converter: the level moves after the slow conversion has started, so only
    // a fresh result taken at the done strobe gives the expected width
    task automatic t_slow();
        @(posedge clk) begin
            dly <= 8'hc8;
            lvb <= 10'h200;
        end
        measure(w, p);
        check("mid width", w, exp_w(10'h200));
        @(posedge clk) lvb <= 10'h100;
        measure(w, p);
        check("slow width", w, exp_w(10'h100));
        check("period", p, TCK * PERT);
    endtask : t_slow
    task automatic give_verdict();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_boot();
        t_select();
        t_slow();
        give_verdict();
    end
    // Tests need about 2450 cycles
    initial begin
        #100000;
        errors++;
        give_verdict();
    end
endmodule : two_position_servo_pulse_gen_tb_top
`default_nettype wire
